// >>> hdl/otpa_pkg.sv
package otpa_pkg;
  // opcodes
  localparam logic [7:0] OP_OTP_READ = 8'h48;
  localparam logic [7:0] OP_OTP_ERASE = 8'h44;
  localparam logic [7:0] OP_TABLE_READ = 8'h5a;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  // bit counts of each command phase
  localparam int OPCODE_BITS = 8;
  localparam int ADDR3_BITS = 24;
  localparam int ADDR4_BITS = 32;
  localparam int DUMMY_BITS = 8;
  // otp sector numbers (4 KiB sectors), array 0..2
  localparam logic [13:0] OTP_SECTOR0 = 14'h3fff;
  localparam logic [13:0] OTP_SECTOR1 = 14'h3ffe;
  localparam logic [13:0] OTP_SECTOR2 = 14'h3ffd;
  localparam int OTP_ARRAY_BYTES = 512;
  // erase timing
  localparam int SECTOR_ERASE_TIME_US = 40000;
  localparam int MCLK_MHZ = 50;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * MCLK_MHZ;
  // erased fill byte and reset value
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] CS_SYNC_IDLE = 3'b111;
  // table header bytes
  localparam logic [7:0] VENDOR_ID_CODE = 8'h5a; // arbitrary value
  localparam int TABLE_LAST_ADDR = 8'h1f;
endpackage

// >>> hdl/otpa_core.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// otp array and parameter table command handler
// ****************************************
// Function
// RQ1: otp read is 48h, 24 or 32 address bits, then eight dummy clocks
// RQ2: opcode and address bits captured on rising serial clock edges
// RQ3: otp byte driven msb first, changing on falling edges
// RQ4: otp read address increments per byte, ffh wraps to 00h
// RQ5: raising chip select ends the otp read and stops output
// RQ6: otp read ignored while write is in progress
// RQ7: otp erase accepted only with write enable latch set
// RQ8: otp erase is 44h plus address, picks one of three 512-byte arrays
// RQ9: erase runs only if chip select rises on byte boundary after address
// RQ10: erase runs for sector erase time holding write in progress
// RQ11: status read still accepted during erase
// RQ12: finished erase clears write enable latch
// RQ13: locked array ignores erase commands
// RQ14: table read is 5ah, 3-byte address, one dummy byte
// RQ15: table byte driven on falling edges after the dummy byte
// RQ16: table address increments and rolls over to zero
// RQ17: raising chip select ends the table read at any time
// RQ18: table read rejected while a write is in progress
// RQ19: bytes 00h-05h hold signature and revision 1.06
// RQ20: byte 06h is header count 03h, 07h is ffh
// RQ21: first header gives id 00h, rev 1.06, length 10h, pointer 30h
// RQ22: second header gives vendor id, rev 1.00, length 04h, pointer 110h
// RQ23: header at 18h gives id 84h, rev 1.00, length 02h, pointer c0h
// RQ24: otp arrays are the first 512 bytes of sectors 16383..16381
// RQ25: undefined table addresses read ffh
module otpa_core #(
  parameter int ERASE_CYCLES = otpa_pkg::SECTOR_ERASE_CYCLES
) (
  // system clock domain
  input wire logic i_mclk,
  input wire logic i_reset,
  // serial link (host drives chip select, clock and data-in)
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_di,
  output logic o_spi_do,
  output logic o_spi_do_oe,
  // status and configuration bits
  input wire logic i_four_byte_mode,
  input wire logic i_wel_set,
  input wire logic [2:0] i_otp_array_lock_bits,
  output logic o_write_in_progress_flag,
  output logic o_write_enable_latch,
  output logic o_erase_done,
  output logic [1:0] o_erase_array,
  // otp storage read port (one byte, combinational answer)
  output logic [1:0] o_otp_rd_array,
  output logic [7:0] o_otp_rd_addr,
  input wire logic [7:0] i_otp_rd_data
);

  // ****************************************
  // link domain: rising edge shift-in
  // ****************************************
  typedef enum logic [5:0] {
    ST_OPCODE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_DUMMY = 6'b00_0100,
    ST_DATA = 6'b00_1000,
    ST_ERDONE = 6'b01_0000,
    ST_IDLE = 6'b10_0000
  } otpa_state_t;

  typedef struct packed {
    otpa_state_t st;
    logic [5:0] cnt;
    logic [7:0] op;
    logic [31:0] addr;
    logic [7:0] byte_addr;
    logic [2:0] bit_idx;
    logic [1:0] erase_arr;
  } otpa_link_t;

  // erase arming; kept across chip select so the system side can read it later
  typedef struct packed {
    logic armed;
    logic [1:0] arr;
  } otpa_hold_t;

  otpa_link_t lk_r;
  otpa_link_t lk_nxt;
  otpa_hold_t hold_r;
  otpa_hold_t hold_nxt;
  logic [1:0] wip_sync_r;
  logic [1:0] wel_sync_r;
  logic [13:0] sec_sel;
  logic wip_link;
  logic wel_link;
  logic [31:0] addr_sh;
  logic [5:0] addr_bits;
  logic [1:0] arr_sel;
  logic arr_hit;
  logic [7:0] tbl_byte;
  logic [7:0] out_byte;

  // two-stage crossing of the busy and latch levels into the link clock
  always_ff @(posedge i_spi_sclk)
  begin
    wip_sync_r <= {wip_sync_r[0], o_write_in_progress_flag};
    wel_sync_r <= {wel_sync_r[0], o_write_enable_latch};
  end
  // the opcode's eight clocks flush the pair before the levels are used
  assign wip_link = wip_sync_r[1];
  assign wel_link = wel_sync_r[1];

  assign addr_bits = i_four_byte_mode ? 6'(otpa_pkg::ADDR4_BITS) : 6'(otpa_pkg::ADDR3_BITS);
  assign addr_sh = {lk_r.addr[30:0], i_spi_di};
  // three-byte addresses sit in the top extended window, so the upper bits are ones
  assign sec_sel = i_four_byte_mode ? addr_sh[25:12] : {2'b11, addr_sh[23:12]};

  // map a command address to an otp array; only the first 512 bytes count
  always_comb
  begin
    arr_sel = 2'd0;
    arr_hit = 1'b0;
    if (sec_sel == otpa_pkg::OTP_SECTOR0 && addr_sh[11:9] == 3'd0)
    begin
      arr_sel = 2'd0;
      arr_hit = 1'b1; // RQ24
    end
    else if (sec_sel == otpa_pkg::OTP_SECTOR1 && addr_sh[11:9] == 3'd0)
    begin
      arr_sel = 2'd1;
      arr_hit = 1'b1;
    end
    else if (sec_sel == otpa_pkg::OTP_SECTOR2 && addr_sh[11:9] == 3'd0)
    begin
      arr_sel = 2'd2;
      arr_hit = 1'b1;
    end
  end

  // header bytes of the discoverable-parameter table, ffh elsewhere
  always_comb
  begin
    case (lk_r.byte_addr)
      8'h00: tbl_byte = 8'h53; // RQ19
      8'h01: tbl_byte = 8'h46;
      8'h02: tbl_byte = 8'h44;
      8'h03: tbl_byte = 8'h50;
      8'h04: tbl_byte = 8'h06;
      8'h05: tbl_byte = 8'h01;
      8'h06: tbl_byte = 8'h03; // RQ20
      8'h08: tbl_byte = 8'h00; // RQ21
      8'h09: tbl_byte = 8'h06;
      8'h0a: tbl_byte = 8'h01;
      8'h0b: tbl_byte = 8'h10;
      8'h0c: tbl_byte = 8'h30;
      8'h0d: tbl_byte = 8'h00;
      8'h0e: tbl_byte = 8'h00;
      8'h10: tbl_byte = otpa_pkg::VENDOR_ID_CODE; // RQ22
      8'h11: tbl_byte = 8'h00;
      8'h12: tbl_byte = 8'h01;
      8'h13: tbl_byte = 8'h04;
      8'h14: tbl_byte = 8'h10;
      8'h15: tbl_byte = 8'h01;
      8'h16: tbl_byte = 8'h00;
      8'h18: tbl_byte = 8'h84; // RQ23
      8'h19: tbl_byte = 8'h00;
      8'h1a: tbl_byte = 8'h01;
      8'h1b: tbl_byte = 8'h02;
      8'h1c: tbl_byte = 8'hc0;
      8'h1d: tbl_byte = 8'h00;
      8'h1e: tbl_byte = 8'h00;
      default: tbl_byte = otpa_pkg::ERASED_BYTE; // RQ25
    endcase
  end

  assign out_byte = (lk_r.op == otpa_pkg::OP_TABLE_READ) ? tbl_byte : i_otp_rd_data;

  // command sequencer; cnt counts bits of the current phase
  always_comb
  begin
    lk_nxt = lk_r;
    case (lk_r.st)
      ST_OPCODE:
      begin
        lk_nxt.op = {lk_r.op[6:0], i_spi_di}; // RQ2
        lk_nxt.cnt = lk_r.cnt + 6'd1;
        if (lk_r.cnt == 6'(otpa_pkg::OPCODE_BITS - 1))
        begin
          lk_nxt.cnt = 6'd0;
          lk_nxt.st = ST_IDLE;
          if (lk_nxt.op == otpa_pkg::OP_OTP_READ && !wip_link)
            lk_nxt.st = ST_ADDR; // RQ1 RQ6
          else if (lk_nxt.op == otpa_pkg::OP_TABLE_READ && !wip_link)
            lk_nxt.st = ST_ADDR; // RQ14 RQ18
          else if (lk_nxt.op == otpa_pkg::OP_OTP_ERASE && wel_link && !wip_link)
            lk_nxt.st = ST_ADDR; // RQ7 RQ8
        end
      end
      ST_ADDR:
      begin
        lk_nxt.addr = addr_sh; // RQ2
        lk_nxt.cnt = lk_r.cnt + 6'd1;
        if ((lk_r.op == otpa_pkg::OP_TABLE_READ && lk_r.cnt == 6'(otpa_pkg::ADDR3_BITS - 1))
            || (lk_r.op != otpa_pkg::OP_TABLE_READ && lk_r.cnt == addr_bits - 6'd1))
        begin
          lk_nxt.cnt = 6'd0;
          lk_nxt.byte_addr = addr_sh[7:0];
          lk_nxt.erase_arr = arr_sel;
          if (lk_r.op == otpa_pkg::OP_OTP_ERASE)
            lk_nxt.st = (arr_hit && !i_otp_array_lock_bits[arr_sel]) ? ST_ERDONE : ST_IDLE; // RQ13
          else
            lk_nxt.st = ST_DUMMY;
        end
      end
      ST_DUMMY:
      begin
        lk_nxt.cnt = lk_r.cnt + 6'd1;
        if (lk_r.cnt == 6'(otpa_pkg::DUMMY_BITS - 1))
        begin
          lk_nxt.cnt = 6'd0;
          lk_nxt.bit_idx = 3'd7;
          lk_nxt.st = ST_DATA; // RQ1 RQ14
        end
      end
      ST_DATA:
      begin
        lk_nxt.bit_idx = lk_r.bit_idx - 3'd1;
        if (lk_r.bit_idx == 3'd0)
          lk_nxt.byte_addr = lk_r.byte_addr + 8'd1; // RQ4 RQ16
      end
      ST_ERDONE:
      begin
        // any further clock breaks the byte boundary and cancels the erase
        lk_nxt.st = ST_IDLE; // RQ9
      end
      default:
        lk_nxt = lk_r;
    endcase
  end

  // arming follows the sequencer; any clock after the boundary disarms it
  always_comb
  begin
    hold_nxt = hold_r;
    hold_nxt.armed = (lk_nxt.st == ST_ERDONE); // RQ9
    if (lk_nxt.st == ST_ERDONE)
      hold_nxt.arr = lk_nxt.erase_arr;
  end

  always_ff @(posedge i_spi_sclk)
  begin
    hold_r <= hold_nxt;
  end

  // chip select high resets the link logic asynchronously
  always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
    begin
      lk_r.st <= ST_OPCODE; // RQ5 RQ17
      lk_r.cnt <= 6'd0;
      lk_r.op <= 8'h00;
      lk_r.addr <= 32'h0000_0000;
      lk_r.byte_addr <= 8'h00;
      lk_r.bit_idx <= 3'd7;
      lk_r.erase_arr <= 2'd0;
    end
    else
      lk_r <= lk_nxt;
  end

  assign o_otp_rd_array = lk_r.erase_arr;
  assign o_otp_rd_addr = lk_r.byte_addr;

  // falling edge output, msb first; released while chip select is high
  always_ff @(negedge i_spi_sclk or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
    begin
      o_spi_do <= 1'b0;
      o_spi_do_oe <= 1'b0; // RQ5
    end
    else
    begin
      o_spi_do <= out_byte[lk_r.bit_idx]; // RQ3 RQ15
      o_spi_do_oe <= (lk_r.st == ST_DATA);
    end
  end

  // ****************************************
  // system domain: erase timer and status
  // ****************************************
  typedef struct packed {
    logic [2:0] cs_sync;
    logic busy;
    logic write_enable_latch;
    logic [31:0] timer;
    logic done;
    logic [1:0] arr;
  } otpa_sys_t;

  otpa_sys_t sy_r;
  otpa_sys_t sy_nxt;

  // chip select rise is seen through two flops; the arming is static while it is high
  always_comb
  begin
    sy_nxt = sy_r;
    sy_nxt.cs_sync = {sy_r.cs_sync[1:0], i_spi_cs_n};
    sy_nxt.done = 1'b0;
    if (!sy_r.busy && sy_r.cs_sync[1] && !sy_r.cs_sync[2] && hold_r.armed && sy_r.write_enable_latch)
    begin
      sy_nxt.busy = 1'b1; // RQ10
      sy_nxt.timer = 32'(ERASE_CYCLES - 1);
      sy_nxt.arr = hold_r.arr;
    end
    else if (sy_r.busy)
    begin
      // status reads are served outside; nothing here blocks them
      sy_nxt.timer = sy_r.timer - 32'd1; // RQ11
      if (sy_r.timer == 32'd0)
      begin
        sy_nxt.busy = 1'b0; // RQ10
        sy_nxt.write_enable_latch = 1'b0; // RQ12
        sy_nxt.done = 1'b1;
      end
    end
    // a set in the cycle the erase ends wins over the clear
    if (i_wel_set)
      sy_nxt.write_enable_latch = 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      sy_r <= '{cs_sync: otpa_pkg::CS_SYNC_IDLE, default: '0};
    else
      sy_r <= sy_nxt;
  end

  assign o_write_in_progress_flag = sy_r.busy;
  assign o_write_enable_latch = sy_r.write_enable_latch;
  assign o_erase_done = sy_r.done;
  assign o_erase_array = sy_r.arr;

  // ****************************************
  // checks
  // ****************************************
  chk_erase_clears_wel: assert property (@(posedge i_mclk) disable iff (i_reset)
    sy_r.busy && sy_r.timer == 32'd0 |=> !o_write_enable_latch && !o_write_in_progress_flag)
    else $error("erase end did not clear latch"); // RQ12
  chk_erase_busy_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(sy_r.busy) |-> sy_r.busy [*8])
    else $error("busy dropped early"); // RQ10
  chk_no_out_idle: assert property (@(posedge i_spi_sclk) disable iff (i_spi_cs_n)
    lk_r.st != ST_DATA |-> !o_spi_do_oe)
    else $error("output outside data phase"); // RQ3
  chk_erase_needs_wel: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(o_write_in_progress_flag) |-> o_write_enable_latch)
    else $error("erase started without latch"); // RQ7
  chk_locked_refused: assert property (@(posedge i_spi_sclk) disable iff (i_spi_cs_n)
    lk_r.st == ST_ADDR && lk_nxt.st == ST_ERDONE |-> !i_otp_array_lock_bits[arr_sel])
    else $error("erase armed on locked array"); // RQ13
  chk_busy_refuses: assert property (@(posedge i_spi_sclk) disable iff (i_spi_cs_n)
    lk_r.st == ST_OPCODE && lk_nxt.st != ST_OPCODE && wip_link |=> lk_r.st == ST_IDLE)
    else $error("command taken while busy"); // RQ6 RQ18

endmodule
`default_nettype wire

// >>> tb/otpa_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host controller model of the serial link
// ****************************************
module otpa_host (
  // link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_di,
  input wire logic i_do,
  input wire logic i_do_oe
);
  logic [7:0] rbuf [64];
  logic oe_seen;
  logic held;
  logic line;
  // a released line shows the inverse of its last bit, so stale data never matches
  assign line = i_do_oe ? i_do : ~held;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di = 1'b0;
    held = 1'b0;
    oe_seen = 1'b0;
  end
  // any drive during a frame is remembered, for refused commands
  always @(posedge i_do_oe) oe_seen = 1'b1;
  // one frame: opcode, na address bits, nd dummy bits, nr bytes, ex stray bits
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na,
                     input int nd, input int nr, input int ex);
    int n;
    int k;
    n = 8 + na + nd;
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    // clock only runs inside the frame; di changes while sclk is low
    for (int i = 0; i < n + 8 * nr + ex; i++)
    begin
      k = i - n;
      if (i < 8) o_di = op[7 - i];
      else if (i < 8 + na) o_di = a[na + 7 - i];
      else o_di = 1'b0;
      #16 o_sclk = 1'b1;
      if (k >= 0 && k < 8 * nr) rbuf[k / 8] = {rbuf[k / 8][6:0], line};
      held = line;
      #16 o_sclk = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    #48;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int EC = 2000;
  localparam logic [7:0] TBL [32] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h03,
    8'hff, 8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
    otpa_pkg::VENDOR_ID_CODE, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hff,
    8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00, 8'hff};
  logic i_mclk, i_reset, i_four_byte_mode, i_wel_set, sclk, cs_n, di;
  logic o_spi_do, o_spi_do_oe, o_write_in_progress_flag, o_write_enable_latch, o_erase_done;
  logic [2:0] i_otp_array_lock_bits;
  logic [1:0] o_erase_array, o_otp_rd_array;
  logic [7:0] o_otp_rd_addr, i_otp_rd_data;
  int failures = 0;
  int samples_checked = 0;
  int busy_cnt = 0;
  int done_cnt = 0;
  // storage model: each byte is a pattern of its array and address
  assign i_otp_rd_data = o_otp_rd_addr ^ {o_otp_rd_array, 6'h15};
  otpa_core #(.ERASE_CYCLES(EC)) dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_di(di), .o_spi_do(o_spi_do),
    .o_spi_do_oe(o_spi_do_oe), .i_four_byte_mode(i_four_byte_mode), .i_wel_set(i_wel_set),
    .i_otp_array_lock_bits(i_otp_array_lock_bits),
    .o_write_in_progress_flag(o_write_in_progress_flag),
    .o_write_enable_latch(o_write_enable_latch), .o_erase_done(o_erase_done),
    .o_erase_array(o_erase_array), .o_otp_rd_array(o_otp_rd_array),
    .o_otp_rd_addr(o_otp_rd_addr), .i_otp_rd_data(i_otp_rd_data));
  otpa_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_di(di), .i_do(o_spi_do),
    .i_do_oe(o_spi_do_oe));
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // busy length and done pulses are counted in the background
  always @(posedge i_mclk)
  begin
    if (o_write_in_progress_flag === 1'b1) busy_cnt <= busy_cnt + 1;
    if (o_erase_done === 1'b1) done_cnt <= done_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // erase frame, then a short settle before the busy flag is judged
  task automatic ers(input logic [31:0] a, input int ex, input logic busy);
    host.cmd(otpa_pkg::OP_OTP_ERASE, a, 24, 0, 0, ex);
    repeat (20) @(posedge i_mclk);
    chk("erase busy", 32'(busy), 32'(o_write_in_progress_flag));
  endtask
  initial
  begin
    #500us;
    failures++;
    conclude();
  end
  initial
  begin
    i_reset = 1'b1;
    i_four_byte_mode = 1'b0;
    i_wel_set = 1'b0;
    i_otp_array_lock_bits = 3'b100;
    repeat (8) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_mclk);
    host.cmd(otpa_pkg::OP_TABLE_READ, 32'h0, 24, 8, 32, 0);
    for (int i = 0; i < 32; i++) chk("table", 32'(TBL[i]), 32'(host.rbuf[i]));
    host.cmd(otpa_pkg::OP_OTP_READ, 32'hfff0fe, 24, 8, 3, 0);
    for (int i = 0; i < 3; i++) chk("otp", 32'(8'(8'hfe + i) ^ 8'h15), 32'(host.rbuf[i]));
    chk("oe after cs", 32'h0, 32'(o_spi_do_oe));
    @(posedge i_mclk) i_four_byte_mode <= 1'b1;
    host.cmd(otpa_pkg::OP_OTP_READ, 32'h03ffe0ff, 32, 8, 2, 0);
    chk("otp4", 32'h0000_55aa, {16'h0, host.rbuf[1], host.rbuf[0]});
    @(posedge i_mclk) i_four_byte_mode <= 1'b0;
    ers(32'hfff000, 0, 1'b0);
    @(posedge i_mclk) i_wel_set <= 1'b1;
    @(posedge i_mclk) i_wel_set <= 1'b0;
    ers(32'hffd000, 0, 1'b0);
    ers(32'hffe000, 1, 1'b0);
    ers(32'h001000, 0, 1'b0);
    chk("latch kept", 32'h1, 32'(o_write_enable_latch));
    busy_cnt = 0;
    ers(32'hffe000, 0, 1'b1);
    chk("erase array", 32'h1, 32'(o_erase_array));
    host.cmd(otpa_pkg::OP_OTP_READ, 32'hfff000, 24, 8, 1, 0);
    chk("busy otp read", 32'h0, 32'(host.oe_seen));
    host.cmd(otpa_pkg::OP_TABLE_READ, 32'h0, 24, 8, 1, 0);
    chk("busy table read", 32'h0, 32'(host.oe_seen));
    host.cmd(otpa_pkg::OP_READ_STATUS, 32'h0, 0, 0, 1, 0);
    chk("status busy bit", 32'h1, 32'(o_write_in_progress_flag));
    for (int n = 0; n < 3000 && o_write_in_progress_flag !== 1'b0; n++) @(posedge i_mclk);
    @(posedge i_mclk);
    chk("erase length", 32'h1, 32'(busy_cnt >= EC - 1 && busy_cnt <= EC + 1));
    chk("done pulses", 32'h1, 32'(done_cnt));
    chk("latch cleared", 32'h0, 32'(o_write_enable_latch));
    conclude();
  end
endmodule
`default_nettype wire
